// *** logic/vrs_sequencer.sv ***
// Operation
// - Compare sampled code against reference over three 16MHz timebase edges.
// - On a detected change wait half a step period, then step one LSB.
// - Cancel the pending step if the difference sign reverses during the wait.
// - Multi-LSB requests step one LSB every 4us until matched.
// - Phase outputs high-impedance throughout shutdown.
// - Supply monitor must report valid; its hysteresis prevents turn-off.
// - Enable comparator must report high; its hysteresis prevents bounce.
// - Logic-level enable must be high; low means disable.
// - All-ones code is no-load and shuts down; other codes restart.
// - After no-load code wait two cycles before shutdown trip level and disable.
// - Latched overvoltage is not cleared by cycling the code.
// - Soft-start begins immediately once all enable conditions hold.
// - Soft-start ramps the reference linearly from zero to the code level.
// - Phase outputs stay high-impedance until ramp reaches pre-biased output.
// - Soft-start opens with 64 switching cycles, then one step per 32us.
// - Sense offset starts at 100mV and falls to zero over 640 cycles.
// - Power-good goes high once soft-start brings output into its window.
// - Codes decode linearly: zero is 0.525V, 111110 is 1.3V, ones is off.
// - Power-good low in shutdown, high only after completed soft-start.
`timescale 1ns/1ps
`include "vrs_map.svh"

module vrs_sequencer #(
   parameter int SS_DELAY_SW   = `VRS_SS_DELAY_SW,
   parameter int OFS_RAMP_SW   = `VRS_OFS_RAMP_SW,
   parameter int RAMP_STEP_CYC = `VRS_RAMP_STEP_CYC
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic        supply_good_in,
   input  wire logic        enable_cmp_in,
   input  wire logic        logic_level_enable_in,
   input  wire logic [5:0]  volt_id_code,
   input  wire logic        sw_cycle_in,
   input  wire logic        prebias_reached_in,
   input  wire logic        window_ok_in,
   input  wire logic        ov_trip_in,
   output logic [5:0]       ref_code_out,
   output logic [6:0]       dac_level_out,
   output logic [3:0]       sense_offset_out,
   output logic             pwm_hiz_out,
   output logic             power_good_out,
   output logic             ov_level_shutdown_out,
   output logic             soft_start_out
);

   localparam int OFS_SEG_SW = OFS_RAMP_SW / 8;

   vrs_pkg::vrs_state_t state_reg;
   vrs_pkg::vrs_state_t state_next;
   logic [6:0]  tb_acc_reg;
   logic        tb_tick_reg;
   logic [5:0]  samp1_reg;
   logic [5:0]  samp2_reg;
   logic [5:0]  samp3_reg;
   logic [5:0]  target_reg;
   logic [1:0]  noload_cnt_reg;
   logic        noload_off;
   logic        ov_latch_reg;
   logic        en_ok;
   logic [9:0]  sw_cnt_reg;
   logic [9:0]  ofs_seg_reg;
   logic [11:0] step_cnt_reg;
   logic [6:0]  base_reg;
   logic [5:0]  ref_code_reg;
   logic        pending_reg;
   logic        gap_reg;
   logic [1:0]  dir_reg;
   logic [1:0]  dir_now;

   // Direction from reference toward target; no-load never a target
   function automatic logic [1:0] vrs_dir(input logic [5:0] tgt, input logic [5:0] cur);
      if (tgt == `VRS_NOLOAD_CODE || tgt == cur)
         return `VRS_DIR_NONE;
      else if (tgt > cur)
         return `VRS_DIR_UP;
      else
         return `VRS_DIR_DOWN;
   endfunction

   // Fractional divider giving a 16 MHz tick from the 100 MHz clock
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         tb_acc_reg  <= 7'h00;
         tb_tick_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         if (tb_acc_reg + `VRS_TB_ACC_INC >= `VRS_TB_ACC_MOD)
         begin
            tb_acc_reg  <= 7'(tb_acc_reg + `VRS_TB_ACC_INC - `VRS_TB_ACC_MOD);
            tb_tick_reg <= 1'b1;
         end
         else
         begin
            tb_acc_reg  <= 7'(tb_acc_reg + `VRS_TB_ACC_INC);
            tb_tick_reg <= 1'b0;
         end
      end
   end

   // Code accepted only when three timebase samples agree
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         samp1_reg  <= `VRS_NOLOAD_CODE;
         samp2_reg  <= `VRS_NOLOAD_CODE;
         samp3_reg  <= `VRS_NOLOAD_CODE;
         target_reg <= `VRS_NOLOAD_CODE;
      end
      else if (clk_en && tb_tick_reg)
      begin
         samp1_reg <= volt_id_code;
         samp2_reg <= samp1_reg;
         samp3_reg <= samp2_reg;
         if (samp1_reg == samp2_reg && samp2_reg == samp3_reg)
            target_reg <= samp3_reg;
      end
   end

   // No-load code counted over switching cycles before it disables
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         noload_cnt_reg <= `VRS_NOLOAD_SW; // Reset target is no-load, so start already counted out
      else if (clk_en)
      begin
         if (target_reg != `VRS_NOLOAD_CODE)
            noload_cnt_reg <= 2'h0;
         else if (sw_cycle_in && noload_cnt_reg != `VRS_NOLOAD_SW)
            noload_cnt_reg <= 2'(noload_cnt_reg + 2'h1);
      end
   end

   assign noload_off = (noload_cnt_reg == `VRS_NOLOAD_SW);

   // Overvoltage latch; a new trip wins over a clearing reset cause
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         ov_latch_reg <= 1'b0;
      else if (clk_en)
      begin
         if (ov_trip_in)
            ov_latch_reg <= 1'b1;
         else if (!supply_good_in || !enable_cmp_in || !logic_level_enable_in)
            ov_latch_reg <= 1'b0;
      end
   end

   // All release conditions together
   assign en_ok = supply_good_in && enable_cmp_in && logic_level_enable_in
                  && !noload_off && !ov_latch_reg;

   // Next state
   always_comb
   begin
      state_next = state_reg;
      if (!en_ok)
         state_next = vrs_pkg::VRS_SHUTDOWN;
      else
      begin
         unique case (state_reg)
            vrs_pkg::VRS_SHUTDOWN:
               state_next = vrs_pkg::VRS_DELAY;
            vrs_pkg::VRS_DELAY:
               if (sw_cycle_in && sw_cnt_reg == 10'(SS_DELAY_SW - 1))
                  state_next = vrs_pkg::VRS_RAMP;
            vrs_pkg::VRS_RAMP:
               if (base_reg == `VRS_DAC_BASE_STEPS && ref_code_reg >= target_reg)
                  state_next = vrs_pkg::VRS_REGULATE;
            vrs_pkg::VRS_REGULATE:
               state_next = vrs_pkg::VRS_REGULATE;
         endcase
      end
   end

   // State register
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         state_reg <= vrs_pkg::VRS_SHUTDOWN;
      else if (clk_en)
         state_reg <= state_next;
   end

   // Switching cycles of the initial delay
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         sw_cnt_reg <= 10'h000;
      else if (clk_en)
      begin
         if (state_reg != vrs_pkg::VRS_DELAY)
            sw_cnt_reg <= 10'h000;
         else if (sw_cycle_in)
            sw_cnt_reg <= 10'(sw_cnt_reg + 10'h001);
      end
   end

   // Sense offset held during delay, then stepped down over the ramp
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         sense_offset_out <= `VRS_OFS_STEPS;
         ofs_seg_reg      <= 10'h000;
      end
      else if (clk_en)
      begin
         if (state_next == vrs_pkg::VRS_SHUTDOWN || state_next == vrs_pkg::VRS_DELAY)
         begin
            sense_offset_out <= `VRS_OFS_STEPS;
            ofs_seg_reg      <= 10'h000;
         end
         else if (sw_cycle_in && sense_offset_out != 4'h0)
         begin
            if (ofs_seg_reg == 10'(OFS_SEG_SW - 1))
            begin
               ofs_seg_reg      <= 10'h000;
               sense_offset_out <= 4'(sense_offset_out - 4'h1);
            end
            else
               ofs_seg_reg <= 10'(ofs_seg_reg + 10'h001);
         end
      end
   end

   assign dir_now = vrs_dir(target_reg, ref_code_reg);

   // Reference: soft-start ramp, then dynamic single-LSB stepping
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         step_cnt_reg <= 12'h000;
         base_reg     <= 7'h00;
         ref_code_reg <= 6'h00;
         pending_reg  <= 1'b0;
         gap_reg      <= 1'b0;
         dir_reg      <= `VRS_DIR_NONE;
      end
      else if (clk_en)
      begin
         if (state_reg == vrs_pkg::VRS_SHUTDOWN || state_reg == vrs_pkg::VRS_DELAY)
         begin
            step_cnt_reg <= 12'h000;
            base_reg     <= 7'h00;
            ref_code_reg <= 6'h00;
            pending_reg  <= 1'b0;
            gap_reg      <= 1'b0;
         end
         else if (state_reg == vrs_pkg::VRS_RAMP)
         begin
            if (step_cnt_reg == 12'(RAMP_STEP_CYC - 1))
            begin
               step_cnt_reg <= 12'h000;
               if (base_reg != `VRS_DAC_BASE_STEPS)
                  base_reg <= 7'(base_reg + 7'h01);
               else if (ref_code_reg < target_reg)
                  ref_code_reg <= 6'(ref_code_reg + 6'h01);
            end
            else
               step_cnt_reg <= 12'(step_cnt_reg + 12'h001);
         end
         else if (pending_reg)
         begin
            if (dir_now != dir_reg)
            begin
               pending_reg  <= 1'b0;
               step_cnt_reg <= 12'h000;
            end
            else if (step_cnt_reg == 12'(`VRS_STEP_HALF_CYC - 1))
            begin
               pending_reg  <= 1'b0;
               gap_reg      <= 1'b1;
               step_cnt_reg <= 12'h000;
               if (dir_reg == `VRS_DIR_UP)
                  ref_code_reg <= 6'(ref_code_reg + 6'h01);
               else
                  ref_code_reg <= 6'(ref_code_reg - 6'h01);
            end
            else
               step_cnt_reg <= 12'(step_cnt_reg + 12'h001);
         end
         else if (gap_reg)
         begin
            if (step_cnt_reg == 12'(`VRS_STEP_HALF_CYC - 2))
            begin
               gap_reg      <= 1'b0;
               step_cnt_reg <= 12'h000;
            end
            else
               step_cnt_reg <= 12'(step_cnt_reg + 12'h001);
         end
         else if (dir_now != `VRS_DIR_NONE)
         begin
            pending_reg  <= 1'b1;
            dir_reg      <= dir_now;
            step_cnt_reg <= 12'h000;
         end
      end
   end

   // Registered reference outputs, one cycle behind the code
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         ref_code_out  <= 6'h00;
         dac_level_out <= 7'h00;
      end
      else if (clk_en)
      begin
         ref_code_out  <= ref_code_reg;
         dac_level_out <= 7'(base_reg + {1'b0, ref_code_reg});
      end
   end

   // Phase drive, power-good and status flags
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         pwm_hiz_out           <= 1'b1;
         power_good_out        <= 1'b0;
         ov_level_shutdown_out <= 1'b1;
         soft_start_out        <= 1'b0;
      end
      else if (clk_en)
      begin
         unique case (state_next)
            vrs_pkg::VRS_SHUTDOWN, vrs_pkg::VRS_DELAY:
               pwm_hiz_out <= 1'b1;
            vrs_pkg::VRS_RAMP:
               if (prebias_reached_in)
                  pwm_hiz_out <= 1'b0;
            vrs_pkg::VRS_REGULATE:
               pwm_hiz_out <= 1'b0;
         endcase
         power_good_out <= (state_next == vrs_pkg::VRS_REGULATE) && window_ok_in;
         ov_level_shutdown_out <= (state_next == vrs_pkg::VRS_SHUTDOWN);
         soft_start_out <= (state_next == vrs_pkg::VRS_DELAY) || (state_next == vrs_pkg::VRS_RAMP);
      end
   end

   // Checks
   sequence s_delay_done;
      clk_en && en_ok && state_reg == vrs_pkg::VRS_DELAY && sw_cycle_in && sw_cnt_reg == 10'(SS_DELAY_SW - 1);
   endsequence

   sequence s_noload_held;
      clk_en && noload_off;
   endsequence

   property p_shutdown_hiz;
      @(posedge clock) disable iff (!rst_n)
      state_reg == vrs_pkg::VRS_SHUTDOWN && clk_en |=> pwm_hiz_out;
   endproperty
   a_shutdown_hiz: assert property (p_shutdown_hiz) else $error("phase outputs driven in shutdown");

   property p_loss_shutdown;
      @(posedge clock) disable iff (!rst_n)
      clk_en && !en_ok |=> state_reg == vrs_pkg::VRS_SHUTDOWN && ov_level_shutdown_out && !power_good_out;
   endproperty
   a_loss_shutdown: assert property (p_loss_shutdown) else $error("enable loss did not shut down");

   property p_immediate_start;
      @(posedge clock) disable iff (!rst_n)
      clk_en && en_ok && state_reg == vrs_pkg::VRS_SHUTDOWN |=> state_reg == vrs_pkg::VRS_DELAY && soft_start_out;
   endproperty
   a_immediate_start: assert property (p_immediate_start) else $error("soft-start not begun at once");

   property p_delay_to_ramp;
      @(posedge clock) disable iff (!rst_n)
      s_delay_done |=> state_reg == vrs_pkg::VRS_RAMP && sense_offset_out == `VRS_OFS_STEPS;
   endproperty
   a_delay_to_ramp: assert property (p_delay_to_ramp) else $error("delay did not end into ramp");

   property p_noload_off;
      @(posedge clock) disable iff (!rst_n)
      s_noload_held |=> state_reg == vrs_pkg::VRS_SHUTDOWN ##0 pwm_hiz_out;
   endproperty
   a_noload_off: assert property (p_noload_off) else $error("no-load code did not disable");

   property p_single_lsb;
      @(posedge clock) disable iff (!rst_n)
      ref_code_reg != $past(ref_code_reg) && $past(state_reg) != vrs_pkg::VRS_SHUTDOWN
         && $past(state_reg) != vrs_pkg::VRS_DELAY
      |-> ref_code_reg == 6'($past(ref_code_reg) + 6'h01) || ref_code_reg == 6'($past(ref_code_reg) - 6'h01);
   endproperty
   a_single_lsb: assert property (p_single_lsb) else $error("reference moved by more than one code");

   property p_cancel;
      @(posedge clock) disable iff (!rst_n)
      clk_en && state_reg == vrs_pkg::VRS_REGULATE && state_next == vrs_pkg::VRS_REGULATE
         && pending_reg && dir_now != dir_reg
      |=> !pending_reg && $stable(ref_code_reg);
   endproperty
   a_cancel: assert property (p_cancel) else $error("reversed step not cancelled");

   property p_half_wait;
      @(posedge clock) disable iff (!rst_n)
      state_reg == vrs_pkg::VRS_REGULATE && $past(state_reg) == vrs_pkg::VRS_REGULATE && $changed(ref_code_reg)
      |-> $past(pending_reg) && $past(step_cnt_reg) == 12'(`VRS_STEP_HALF_CYC - 1) && gap_reg;
   endproperty
   a_half_wait: assert property (p_half_wait) else $error("step taken before half period");

   property p_ov_hold;
      @(posedge clock) disable iff (!rst_n)
      clk_en && ov_latch_reg && supply_good_in && enable_cmp_in && logic_level_enable_in |=> ov_latch_reg;
   endproperty
   a_ov_hold: assert property (p_ov_hold) else $error("overvoltage latch cleared by code");

   property p_power_good_out;
      @(posedge clock) disable iff (!rst_n)
      power_good_out |-> state_reg == vrs_pkg::VRS_REGULATE && !pwm_hiz_out;
   endproperty
   a_power_good_out: assert property (p_power_good_out) else $error("power-good high outside regulation");

endmodule // vrs_sequencer

// *** shared/vrs_map.svh ***
`ifndef VRS_MAP_SVH
`define VRS_MAP_SVH

// Identification code layout
`define VRS_CODE_W          6
`define VRS_NOLOAD_CODE     6'h3F
`define VRS_DAC_BASE_STEPS  7'h2A

// Step direction encodings
`define VRS_DIR_NONE        2'h0
`define VRS_DIR_UP          2'h1
`define VRS_DIR_DOWN        2'h2

// Clock and 16 MHz timebase accumulator
`define VRS_CLK_PERIOD_NS   10
`define VRS_TB_ACC_INC      7'h10
`define VRS_TB_ACC_MOD      7'h64

// Dynamic step timing: one step per 4000 ns, half period wait
`define VRS_STEP_PERIOD_NS  4000
`define VRS_STEP_HALF_CYC   (`VRS_STEP_PERIOD_NS / 2 / `VRS_CLK_PERIOD_NS)

// Soft-start ramp: one step per 32000 ns
`define VRS_RAMP_STEP_NS    32000
`define VRS_RAMP_STEP_CYC   (`VRS_RAMP_STEP_NS / `VRS_CLK_PERIOD_NS)

// Soft-start and no-load counts in switching cycles, and offset steps
`define VRS_SS_DELAY_SW     64
`define VRS_OFS_RAMP_SW     640
`define VRS_OFS_STEPS       4'h8
`define VRS_NOLOAD_SW       2'h2

`endif

// *** shared/vrs_pkg.sv ***
package vrs_pkg;

   // Sequencer states
   typedef enum logic [1:0] {
      VRS_SHUTDOWN,
      VRS_DELAY,
      VRS_RAMP,
      VRS_REGULATE
   } vrs_state_t;

endpackage

// *** sim/vrs_cpu_model.sv ***
`timescale 1ns/1ps

module vrs_cpu_model #(
   parameter int STEP_GAP = 400
) (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic [5:0] target,
   input  wire logic       jump,
   output logic [5:0]      volt_id_code
);
   int gap_cnt;

   // Walks toward target one LSB per gap, or jumps at once when asked
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         volt_id_code <= 6'h3F; // Pins pulled up while the processor is idle
         gap_cnt      <= 0;
      end
      else if (jump)
         volt_id_code <= target;
      else if (gap_cnt != 0)
         gap_cnt <= gap_cnt - 1;
      else if (volt_id_code != target)
      begin
         volt_id_code <= (volt_id_code < target) ? volt_id_code + 6'h01 : volt_id_code - 6'h01;
         gap_cnt      <= STEP_GAP;
      end
   end
endmodule // vrs_cpu_model

// *** sim/vrs_sequencer_tb_top.sv ***
`timescale 1ns/1ps

module vrs_sequencer_tb_top;
   typedef struct packed {logic s; logic c; logic l; logic [5:0] code; logic ss;} vrs_row_t;

   logic       clock = 0, rst_n = 0, sw_cycle_in = 0, prebias_reached_in = 0, window_ok_in = 1, ov_trip_in = 0;
   localparam int RAMP_CYC = 400; // Shortened ramp step keeps the run brief
   logic       supply_good_in = 0, enable_cmp_in = 0, logic_level_enable_in = 0, jump = 1, clk_en = 1;
   logic [5:0] target = 6'h3F, volt_id_code, ref_code_out;
   logic [6:0] dac_level_out;
   logic [3:0] sense_offset_out;
   logic       pwm_hiz_out, power_good_out, ov_level_shutdown_out, soft_start_out;
   int         fails = 0, n_compared = 0, cycles = 0, sw_cnt = 0, t, i;
   // Enable rows: supply, comparator, logic enable, code, expected soft-start
   const vrs_row_t rows[5] = '{
      '{1'b0, 1'b1, 1'b1, 6'h05, 1'b0},
      '{1'b1, 1'b0, 1'b1, 6'h05, 1'b0},
      '{1'b1, 1'b1, 1'b0, 6'h05, 1'b0},
      '{1'b1, 1'b1, 1'b1, 6'h3F, 1'b0},
      '{1'b1, 1'b1, 1'b1, 6'h05, 1'b1}};

   vrs_sequencer #(.SS_DELAY_SW(4), .OFS_RAMP_SW(40), .RAMP_STEP_CYC(RAMP_CYC)) dut_u (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .supply_good_in(supply_good_in),
      .enable_cmp_in(enable_cmp_in), .logic_level_enable_in(logic_level_enable_in),
      .volt_id_code(volt_id_code), .sw_cycle_in(sw_cycle_in), .prebias_reached_in(prebias_reached_in),
      .window_ok_in(window_ok_in), .ov_trip_in(ov_trip_in), .ref_code_out(ref_code_out),
      .dac_level_out(dac_level_out), .sense_offset_out(sense_offset_out), .pwm_hiz_out(pwm_hiz_out),
      .power_good_out(power_good_out), .ov_level_shutdown_out(ov_level_shutdown_out),
      .soft_start_out(soft_start_out));

   vrs_cpu_model cpu_u (.clock(clock), .rst_n(rst_n), .target(target), .jump(jump), .volt_id_code(volt_id_code));

   always #5 clock = ~clock;

   // Switching-cycle pulse every 8 clocks, and the hang limit
   always @(posedge clock)
   begin
      sw_cnt      <= (sw_cnt == 7) ? 0 : sw_cnt + 1;
      sw_cycle_in <= (sw_cnt == 7);
      cycles      <= cycles + 1;
      if (cycles == 40000)
      begin
         fails = fails + 1;
         $display("unexpected timeout: expected completion, seen %0d cycles", cycles);
         tally_and_finish();
      end
   end

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic drive(input logic s, input logic c, input logic l, input logic [5:0] code);
      @(posedge clock);
      supply_good_in        <= s;
      enable_cmp_in         <= c;
      logic_level_enable_in <= l;
      target                <= code;
   endtask

   // Counts clocks until the reference (or level) shows v, capped
   task automatic wait_val(input bit use_ref, input logic [6:0] v, output int n);
      n = 0;
      while ((use_ref ? {1'b0, ref_code_out} : dac_level_out) !== v && n < 4000)
      begin
         cyc(1);
         n++;
      end
   endtask

   task automatic chk_reset();
      chk("pwm_hiz_out", pwm_hiz_out, 1);
      chk("power_good_out", power_good_out, 0);
      chk("ov_level_shutdown_out", ov_level_shutdown_out, 1);
      chk("soft_start_out", soft_start_out, 0);
      chk("ref_code_out", ref_code_out, 0);
      chk("dac_level_out", dac_level_out, 0);
      chk("sense_offset_out", sense_offset_out, 8);
   endtask

   task automatic tally_and_finish();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      cyc(5);
      chk_reset();
      @(posedge clock) rst_n <= 1;
      // Enable combinations from shutdown
      for (i = 0; i < 5; i++)
      begin
         // Settle the row's code while disabled
         drive(1'b0, 1'b0, 1'b0, rows[i].code);
         cyc(60);
         drive(rows[i].s, rows[i].c, rows[i].l, rows[i].code);
         cyc(24);
         chk("soft_start_out", soft_start_out, rows[i].ss);
         chk("pwm_hiz_out", pwm_hiz_out, 1);
         drive(1'b0, 1'b0, 1'b0, rows[i].code);
         cyc(4);
         chk("soft_start_out", soft_start_out, 0);
      end
      // Full soft-start to code zero
      drive(1'b1, 1'b1, 1'b0, 6'h00);
      cyc(40);
      drive(1'b1, 1'b1, 1'b1, 6'h00);
      cyc(2);
      chk("soft_start_out", soft_start_out, 1);
      cyc(16);
      chk("dac_level_out", dac_level_out, 0);
      chk("sense_offset_out", sense_offset_out, 8);
      wait_val(0, 7'h01, t);
      wait_val(0, 7'h02, t);
      chk("ramp step clocks", 16'(t), 16'(RAMP_CYC));
      chk("sense_offset_out", sense_offset_out, 0);
      chk("pwm_hiz_out", pwm_hiz_out, 1);
      chk("power_good_out", power_good_out, 0);
      @(posedge clock) prebias_reached_in <= 1;
      cyc(2);
      chk("pwm_hiz_out", pwm_hiz_out, 0);
      for (i = 3; i <= 42; i++)
      begin
         wait_val(0, 7'(i), t);
         chk("single ramp step", 16'(t <= RAMP_CYC), 1);
      end
      cyc(3);
      chk("power_good_out", power_good_out, 1);
      chk("soft_start_out", soft_start_out, 0);
      chk("ov_level_shutdown_out", ov_level_shutdown_out, 0);
      // Single-LSB change walked by the processor
      @(posedge clock);
      jump   <= 0;
      target <= 6'h01;
      wait_val(1, 7'h01, t);
      chk("step delay in range", 16'(t >= 200 && t <= 230), 1);
      chk("dac_level_out", dac_level_out, 43);
      // Request reverts during the post-step gap, before any wait starts: no step
      @(posedge clock);
      jump   <= 1;
      target <= 6'h02;
      cyc(60);
      @(posedge clock) target <= 6'h01;
      cyc(450);
      chk("ref_code_out", ref_code_out, 1);
      // Multi-LSB jump walks at one LSB per step period
      @(posedge clock) target <= 6'h05;
      wait_val(1, 7'h02, t);
      wait_val(1, 7'h03, t);
      chk("walk step clocks", 16'(t), 400);
      wait_val(1, 7'h05, t);
      chk("dac_level_out", dac_level_out, 47);
      // Single step downward once the step gap has passed
      cyc(400);
      @(posedge clock) target <= 6'h04;
      wait_val(1, 7'h04, t);
      chk("down step delay in range", 16'(t >= 200 && t <= 240), 1);
      chk("dac_level_out", dac_level_out, 46);
      // Power-good follows the output window
      @(posedge clock) window_ok_in <= 0;
      cyc(2);
      chk("power_good_out", power_good_out, 0);
      @(posedge clock) window_ok_in <= 1;
      cyc(2);
      chk("power_good_out", power_good_out, 1);
      // Clock enable low freezes the block, then no-load shuts down
      @(posedge clock)
      begin
         clk_en <= 0;
         target <= 6'h3F;
      end
      cyc(80);
      chk("pwm_hiz_out", pwm_hiz_out, 0);
      chk("power_good_out", power_good_out, 1);
      @(posedge clock) clk_en <= 1;
      cyc(60);
      chk("pwm_hiz_out", pwm_hiz_out, 1);
      chk("ov_level_shutdown_out", ov_level_shutdown_out, 1);
      chk("power_good_out", power_good_out, 0);
      @(posedge clock) target <= 6'h05;
      cyc(40);
      chk("soft_start_out", soft_start_out, 1);
      chk("dac_level_out", dac_level_out, 0);
      // Overvoltage latch survives code cycling
      @(posedge clock) ov_trip_in <= 1;
      @(posedge clock) ov_trip_in <= 0;
      cyc(3);
      chk("soft_start_out", soft_start_out, 0);
      @(posedge clock) target <= 6'h3F;
      cyc(40);
      @(posedge clock) target <= 6'h05;
      cyc(40);
      chk("soft_start_out", soft_start_out, 0);
      drive(1'b1, 1'b1, 1'b0, 6'h05);
      cyc(4);
      drive(1'b1, 1'b1, 1'b1, 6'h05);
      cyc(3);
      chk("soft_start_out", soft_start_out, 1);
      // Reset in mid-run
      @(posedge clock) rst_n <= 0;
      cyc(2);
      chk_reset();
      // Release again: shut down until a valid code settles, then restart
      @(posedge clock) rst_n <= 1;
      cyc(2);
      chk("soft_start_out", soft_start_out, 0);
      cyc(40);
      chk("soft_start_out", soft_start_out, 1);
      tally_and_finish();
   end
endmodule // vrs_sequencer_tb_top
